//--- pifb_cfg.svh
// constants for the peripheral interrupt flag bank
`ifndef PIFB_CFG_SVH
`define PIFB_CFG_SVH

// register indices; byte address is four times the index
`define PIFB_IDX_CC        14'h070D
`define PIFB_IDX_CZ        14'h070E
`define PIFB_IDX_SP        14'h070F
`define PIFB_IDX_TE        14'h0710
`define PIFB_ADDR_W        16

// implemented bits of each flag register; the serial_port_flags mask covers only its sticky half
`define PIFB_MASK_CC       8'hC3
`define PIFB_MASK_CZ       8'h43
`define PIFB_MASK_SP_HW    8'h0F
`define PIFB_MASK_TE       8'h3F
`define PIFB_FLAGS_RESET   8'h00

// clock_and_converter_flags fields
`define PIFB_CC_OSC        7
`define PIFB_CC_CSW        6
`define PIFB_CC_CTHR       1
`define PIFB_CC_CDONE      0

// compare_zero_cross_flags fields
`define PIFB_CZ_ZC         6
`define PIFB_CZ_CMP_LO     0

// serial_port_flags fields
`define PIFB_SP_RX2        7
`define PIFB_SP_TX2        6
`define PIFB_SP_RX1        5
`define PIFB_SP_TX1        4
`define PIFB_SP_BCL2       3
`define PIFB_SP_DONE2      2
`define PIFB_SP_BCL1       1
`define PIFB_SP_DONE1      0

// timer_event_flags fields
`define PIFB_TE_LO         0
`define PIFB_TE_T4         3
`define PIFB_TE_T6         5
`define PIFB_TE_UNUSED_HI  7
`define PIFB_TE_UNUSED_LO  6

// bus answers
`define PIFB_RESP_OKAY     2'h0
`define PIFB_RESP_SLVERR   2'h2
`define PIFB_RDATA_PAD     24'h000000

`endif

//--- pifb_pkg.sv
// types shared by the peripheral interrupt flag bank
package pifb_pkg;
  typedef logic [7:0] pifb_flags_t;
  typedef enum logic [2:0] {
    PIFB_SEL_NONE,
    PIFB_SEL_CC,
    PIFB_SEL_CZ,
    PIFB_SEL_SP,
    PIFB_SEL_TE
  } pifb_sel_t;
endpackage

//--- pifb_sticky_bank.sv
// one bank of sticky flags: hardware sets, software writes
`timescale 1ns/100ps
`default_nettype none
`include "pifb_cfg.svh"
module pifb_sticky_bank #(
  parameter pifb_pkg::pifb_flags_t MASK = `PIFB_MASK_CC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire pifb_pkg::pifb_flags_t set_evt,
  input  wire logic                 wr_en,
  input  wire pifb_pkg::pifb_flags_t wr_data,
  output var  pifb_pkg::pifb_flags_t flags
);
  import pifb_pkg::*;

  pifb_flags_t next_flags;

  always_comb begin
    next_flags = wr_en ? wr_data : flags;
    next_flags = (next_flags | set_evt) & MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `PIFB_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule
`default_nettype wire

//--- pifb_top.sv
// peripheral interrupt flag bank with an axi4-lite register slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pifb_cfg.svh"
module pifb_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [`PIFB_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [`PIFB_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       osc_fail_evt,
  input  wire logic                       clk_switch_evt,
  input  wire logic                       conv_complete_evt,
  input  wire logic                       zero_cross_evt,
  input  wire logic [1:0]                 comparator_evt,
  input  wire logic [1:0]                 async_rx_not_empty,
  input  wire logic [1:0]                 async_tx_has_space,
  input  wire logic [1:0]                 sync_collision_evt,
  input  wire logic [1:0]                 sync_done_evt,
  input  wire logic [5:0]                 timer_evt,
  output var  pifb_pkg::pifb_flags_t      clock_and_converter_flags,
  output var  pifb_pkg::pifb_flags_t      compare_zero_cross_flags,
  output var  pifb_pkg::pifb_flags_t      serial_port_flags,
  output var  pifb_pkg::pifb_flags_t      timer_event_flags
);
  import pifb_pkg::*;

  // decode shared by the read and the write path
  function automatic pifb_sel_t decode_sel(input logic [`PIFB_ADDR_W-1:0] addr);
    pifb_sel_t sel;
    sel = PIFB_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[`PIFB_ADDR_W-1:2])
        `PIFB_IDX_CC: sel = PIFB_SEL_CC;
        `PIFB_IDX_CZ: sel = PIFB_SEL_CZ;
        `PIFB_IDX_SP: sel = PIFB_SEL_SP;
        `PIFB_IDX_TE: sel = PIFB_SEL_TE;
        default:      sel = PIFB_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // write channel state
  logic                    aw_held;
  logic                    w_held;
  logic [`PIFB_ADDR_W-1:0] aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    next_aw_held;
  logic                    next_w_held;
  logic [`PIFB_ADDR_W-1:0] next_aw_addr;
  logic [31:0]             next_w_data;
  logic [3:0]              next_w_strb;
  logic                    next_bvalid;
  logic [1:0]              next_bresp;
  logic                    wr_fire;
  pifb_sel_t               wr_sel;
  logic                    wr_lane;

  // read channel state
  logic                    next_rvalid;
  logic [1:0]              next_rresp;
  logic [31:0]             next_rdata;
  pifb_sel_t               rd_sel;

  // flag sources
  pifb_flags_t             cc_set;
  pifb_flags_t             cz_set;
  pifb_flags_t             sp_set;
  pifb_flags_t             te_set;
  pifb_flags_t             sp_sticky;
  pifb_flags_t             sp_level;
  pifb_flags_t             next_sp_level;

  // address and data are taken independently, one write in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel        = decode_sel(aw_addr);
  assign wr_lane       = wr_fire && w_strb[0];

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_sel == PIFB_SEL_NONE) ? `PIFB_RESP_SLVERR : `PIFB_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIFB_RESP_OKAY;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  // read path: data registered, unmapped reads answer zero with slverr
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel        = decode_sel(s_axi_araddr);

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `PIFB_RESP_OKAY;
      unique case (rd_sel)
        PIFB_SEL_CC:   next_rdata = {`PIFB_RDATA_PAD, clock_and_converter_flags};
        PIFB_SEL_CZ:   next_rdata = {`PIFB_RDATA_PAD, compare_zero_cross_flags};
        PIFB_SEL_SP:   next_rdata = {`PIFB_RDATA_PAD, serial_port_flags};
        PIFB_SEL_TE:   next_rdata = {`PIFB_RDATA_PAD, timer_event_flags};
        PIFB_SEL_NONE: begin
          next_rdata = '0;
          next_rresp = `PIFB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `PIFB_RESP_OKAY;
      s_axi_rdata  <= '0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

  // set conditions; enables live elsewhere and never gate these
  always_comb begin
    cc_set = '0;
    cz_set = '0;
    sp_set = '0;
    te_set = '0;
    cc_set[`PIFB_CC_OSC]   = osc_fail_evt;
    cc_set[`PIFB_CC_CSW]   = clk_switch_evt;
    cc_set[`PIFB_CC_CTHR]  = conv_complete_evt;
    cc_set[`PIFB_CC_CDONE] = conv_complete_evt;
    cz_set[`PIFB_CZ_ZC]    = zero_cross_evt;
    cz_set[`PIFB_CZ_CMP_LO +: 2] = comparator_evt;
    sp_set[`PIFB_SP_BCL1]  = sync_collision_evt[0];
    sp_set[`PIFB_SP_BCL2]  = sync_collision_evt[1];
    sp_set[`PIFB_SP_DONE1] = sync_done_evt[0];
    sp_set[`PIFB_SP_DONE2] = sync_done_evt[1];
    te_set[`PIFB_TE_LO +: 6] = timer_evt;
  end

  pifb_sticky_bank #(.MASK(`PIFB_MASK_CC)) u_cc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (cc_set),
    .wr_en   (wr_lane && (wr_sel == PIFB_SEL_CC)),
    .wr_data (w_data[7:0]),
    .flags   (clock_and_converter_flags)
  );

  pifb_sticky_bank #(.MASK(`PIFB_MASK_CZ)) u_cz (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (cz_set),
    .wr_en   (wr_lane && (wr_sel == PIFB_SEL_CZ)),
    .wr_data (w_data[7:0]),
    .flags   (compare_zero_cross_flags)
  );

  // writes reach only the sticky half
  pifb_sticky_bank #(.MASK(`PIFB_MASK_SP_HW)) u_sp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (sp_set),
    .wr_en   (wr_lane && (wr_sel == PIFB_SEL_SP)),
    .wr_data (w_data[7:0]),
    .flags   (sp_sticky)
  );

  pifb_sticky_bank #(.MASK(`PIFB_MASK_TE)) u_te (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (te_set),
    .wr_en   (wr_lane && (wr_sel == PIFB_SEL_TE)),
    .wr_data (w_data[7:0]),
    .flags   (timer_event_flags)
  );

  // buffer levels, registered one cycle so the read data stays a flop
  always_comb begin
    next_sp_level = '0;
    next_sp_level[`PIFB_SP_RX1] = async_rx_not_empty[0];
    next_sp_level[`PIFB_SP_RX2] = async_rx_not_empty[1];
    next_sp_level[`PIFB_SP_TX1] = async_tx_has_space[0];
    next_sp_level[`PIFB_SP_TX2] = async_tx_has_space[1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_level <= `PIFB_FLAGS_RESET;
    end else begin
      sp_level <= next_sp_level;
    end
  end

  assign serial_port_flags = sp_level | sp_sticky;

  // checks
  logic sp_clr_bcl1;
  assign sp_clr_bcl1 = wr_lane && (wr_sel == PIFB_SEL_SP) && !w_data[`PIFB_SP_BCL1];

  osc_fail_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    osc_fail_evt |=> clock_and_converter_flags[`PIFB_CC_OSC])
    else $error("osc fail flag not set");

  clk_switch_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_switch_evt |=> clock_and_converter_flags[`PIFB_CC_CSW])
    else $error("clock switch flag not set");

  conv_flags_pair_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_complete_evt |=> clock_and_converter_flags[`PIFB_CC_CTHR]
      && clock_and_converter_flags[`PIFB_CC_CDONE])
    else $error("converter flags not both set");

  zero_cross_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    zero_cross_evt |=> compare_zero_cross_flags[`PIFB_CZ_ZC])
    else $error("zero-cross flag not set");

  comparator_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    comparator_evt[1] |=> compare_zero_cross_flags[`PIFB_CZ_CMP_LO + 1])
    else $error("comparator flag not set");

  // the edge that releases reset still loads the cleared level, so start one later
  rx_level_follow_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> serial_port_flags[`PIFB_SP_RX2] == $past(async_rx_not_empty[1]))
    else $error("rx flag does not follow buffer");

  tx_level_follow_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> serial_port_flags[`PIFB_SP_TX1] == $past(async_tx_has_space[0]))
    else $error("tx flag does not follow buffer");

  collision_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    serial_port_flags[`PIFB_SP_BCL1] && !sp_clr_bcl1
      |=> serial_port_flags[`PIFB_SP_BCL1])
    else $error("collision flag dropped without a clear");

  set_beats_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_collision_evt[0] && sp_clr_bcl1 |=> serial_port_flags[`PIFB_SP_BCL1])
    else $error("clear won over a set");

  timer_unused_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer_event_flags[`PIFB_TE_UNUSED_HI:`PIFB_TE_UNUSED_LO] == 2'h0)
    else $error("unused timer bits not zero");

  timer6_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer_evt[`PIFB_TE_T6] |=> timer_event_flags[`PIFB_TE_T6])
    else $error("timer 6 flag not set");

  timer4_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer_evt[`PIFB_TE_T4] |=> timer_event_flags[`PIFB_TE_T4])
    else $error("timer 4 flag not set");

  no_hw_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(timer_event_flags[`PIFB_TE_T4]) |-> $past(wr_lane)
      && ($past(wr_sel) == PIFB_SEL_TE))
    else $error("timer flag cleared without a write");

  reset_clear_a: assert property (
    @(posedge aclk)
    !aresetn |=> (serial_port_flags == `PIFB_FLAGS_RESET))
    else $error("flags not zero after reset");

  write_answer_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  write_done_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready && s_axi_bresp == `PIFB_RESP_OKAY);

  read_done_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && s_axi_rresp == `PIFB_RESP_OKAY);

  unmapped_read_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == `PIFB_RESP_SLVERR);

  set_clear_race_c: cover property (
    @(posedge aclk) disable iff (!aresetn)
    sync_collision_evt[0] && sp_clr_bcl1);
endmodule
`default_nettype wire

//--- pifb_periph_model.sv
// far-side peripheral model: serial buffer occupancy levels
`timescale 1ns/100ps
`default_nettype none
module pifb_periph_model #(
  parameter int DEPTH = 2
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] rx_push,
  input  wire logic [1:0] rx_pop,
  input  wire logic [1:0] tx_push,
  input  wire logic [1:0] tx_pop,
  output var  logic [1:0] async_rx_not_empty,
  output var  logic [1:0] async_tx_has_space
);
  int rx_cnt [2];
  int tx_cnt [2];
  always @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn) begin
        rx_cnt[p] <= 0;
        tx_cnt[p] <= 0;
      end else begin
        if (rx_push[p] && rx_cnt[p] < DEPTH) rx_cnt[p] <= rx_cnt[p] + 1;
        else if (rx_pop[p] && rx_cnt[p] > 0) rx_cnt[p] <= rx_cnt[p] - 1;
        if (tx_push[p] && tx_cnt[p] < DEPTH) tx_cnt[p] <= tx_cnt[p] + 1;
        else if (tx_pop[p] && tx_cnt[p] > 0) tx_cnt[p] <= tx_cnt[p] - 1;
      end
    end
  end
  // levels only; shift-register completion is not modelled here
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      async_rx_not_empty[p] = (rx_cnt[p] != 0);
      async_tx_has_space[p] = (tx_cnt[p] < DEPTH);
    end
  end
endmodule
`default_nettype wire

//--- peripheral_irq_flag_bank_test.sv
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/100ps
`default_nettype none
`include "pifb_cfg.svh"
module peripheral_irq_flag_bank_test;
  import pifb_pkg::*;
  localparam logic [15:0] ADDR [4] = '{{`PIFB_IDX_CC, 2'b00}, {`PIFB_IDX_CZ, 2'b00},
                                       {`PIFB_IDX_SP, 2'b00}, {`PIFB_IDX_TE, 2'b00}};
  localparam int EV_REG [16] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3};
  localparam logic [7:0] EV_MASK [16] = '{8'h80, 8'h40, 8'h03, 8'h40, 8'h01, 8'h02, 8'h02,
    8'h08, 8'h01, 8'h04, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
  // empty tx buffers have space, so the serial register idles at this value
  localparam logic [7:0] TX_IDLE = 8'h50;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [15:0] evt = 16'h0000;
  logic [1:0]  rx_push = 2'h0;
  logic [1:0]  rx_pop = 2'h0;
  logic [1:0]  tx_push = 2'h0;
  logic [1:0]  tx_pop = 2'h0;
  logic [1:0]  rx_ne;
  logic [1:0]  tx_sp;
  pifb_flags_t flg [4];
  int          miscompares = 0;
  int          checks = 0;
  logic [31:0] d;
  logic [1:0]  r;

  always #25 aclk = ~aclk;

  pifb_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .osc_fail_evt(evt[0]), .clk_switch_evt(evt[1]), .conv_complete_evt(evt[2]),
    .zero_cross_evt(evt[3]), .comparator_evt(evt[5:4]), .async_rx_not_empty(rx_ne),
    .async_tx_has_space(tx_sp), .sync_collision_evt(evt[7:6]), .sync_done_evt(evt[9:8]),
    .timer_evt(evt[15:10]), .clock_and_converter_flags(flg[0]),
    .compare_zero_cross_flags(flg[1]), .serial_port_flags(flg[2]), .timer_event_flags(flg[3]));

  pifb_periph_model #(.DEPTH(2)) periph_u (.aclk(aclk), .aresetn(aresetn), .rx_push(rx_push),
    .rx_pop(rx_pop), .tx_push(tx_push), .tx_pop(tx_pop), .async_rx_not_empty(rx_ne),
    .async_tx_has_space(tx_sp));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      miscompares++;
      $display("[ERR] bus answer expected within 100 cycles seen none");
      end_of_test();
    end
  endtask

  task automatic axi_wr(input logic [15:0] a, input logic [7:0] v, input logic [3:0] st,
                        output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    // bready stays up: lowering it here would clash with the next call's raise
    resp = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic test_sticky();
    logic [7:0] exp [4];
    int         g;
    for (int k = 0; k < 16; k++) begin
      g = EV_REG[k];
      exp = '{8'h00, 8'h00, TX_IDLE, 8'h00};
      exp[g] = exp[g] | EV_MASK[k];
      evt <= 16'h0001 << k;
      @(posedge aclk);
      evt <= 16'h0000;
      // flags must outlast the source by many cycles
      repeat (10) @(posedge aclk);
      axi_rd(ADDR[g], d, r);
      chk("flag read", d, {24'h000000, exp[g]});
      for (int i = 0; i < 4; i++) chk("flag port", flg[i], exp[i]);
      axi_wr(ADDR[g], 8'h00, 4'hF, r);
      chk("clear resp", r, `PIFB_RESP_OKAY);
      chk("cleared", flg[g], (g == 2) ? TX_IDLE : 8'h00);
    end
    $display("sticky sweep done");
  endtask

  task automatic test_collide();
    // one-cycle collision pulse seen at the very edge the clearing write applies
    fork
      axi_wr(ADDR[2], 8'h00, 4'hF, r);
      begin
        @(posedge aclk);
        evt <= 16'h0040;
        @(posedge aclk);
        evt <= 16'h0000;
      end
    join
    chk("set beats clear", flg[2], TX_IDLE | 8'h02);
    axi_wr(ADDR[2], 8'h00, 4'hF, r);
    chk("late clear", flg[2], TX_IDLE);
    axi_wr(ADDR[3], 8'hFF, 4'hF, r);
    axi_rd(ADDR[3], d, r);
    chk("unused timer bits", d, 32'h0000003F);
    axi_wr(ADDR[3], 8'h00, 4'h0, r);
    chk("no strobe resp", r, `PIFB_RESP_OKAY);
    chk("no strobe kept", flg[3], 8'h3F);
    axi_wr(ADDR[3], 8'h00, 4'hF, r);
    axi_wr(16'h0000, 8'hFF, 4'hF, r);
    chk("unmapped wr", r, `PIFB_RESP_SLVERR);
    axi_wr(ADDR[3] + 16'h0001, 8'hFF, 4'hF, r);
    chk("unaligned wr", r, `PIFB_RESP_SLVERR);
    chk("unaligned no effect", flg[3], 8'h00);
    axi_rd(16'h0000, d, r);
    chk("unmapped rd resp", r, `PIFB_RESP_SLVERR);
    chk("unmapped rd data", d, 32'h00000000);
    $display("collision and bus error test done");
  endtask

  task automatic test_serial();
    logic [7:0] rxb;
    logic [7:0] txb;
    for (int p = 0; p < 2; p++) begin
      rxb = 8'h20 << (2 * p);
      txb = 8'h10 << (2 * p);
      rx_push <= 2'h1 << p;
      @(posedge aclk);
      rx_push <= 2'h0;
      repeat (2) @(posedge aclk);
      axi_rd(ADDR[2], d, r);
      chk("rx level", d, {24'h000000, TX_IDLE | rxb});
      axi_wr(ADDR[2], 8'h00, 4'hF, r);
      chk("rx read only", flg[2], TX_IDLE | rxb);
      rx_pop <= 2'h1 << p;
      @(posedge aclk);
      rx_pop <= 2'h0;
      repeat (2) @(posedge aclk);
      chk("rx drained", flg[2], TX_IDLE);
      // two writes fill the buffer; no write is offered once it is full
      tx_push <= 2'h1 << p;
      repeat (2) @(posedge aclk);
      tx_push <= 2'h0;
      repeat (2) @(posedge aclk);
      chk("tx full", flg[2], TX_IDLE & ~txb);
      axi_wr(ADDR[2], 8'hF0, 4'hF, r);
      chk("tx read only", flg[2], TX_IDLE & ~txb);
      tx_pop <= 2'h1 << p;
      @(posedge aclk);
      tx_pop <= 2'h0;
      repeat (2) @(posedge aclk);
      chk("tx space back", flg[2], TX_IDLE);
    end
    $display("serial level test done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    for (int i = 0; i < 4; i++) chk("reset flags", flg[i], `PIFB_FLAGS_RESET);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      axi_rd(ADDR[i], d, r);
      chk("reset read", d, (i == 2) ? {24'h000000, TX_IDLE} : 32'h00000000);
    end
    $display("reset test done");
    test_sticky();
    test_collide();
    test_serial();
    end_of_test();
  end
endmodule
`default_nettype wire
